/* hw/fal_log_store.sv */
`timescale 1ns/1ns
`default_nettype none
module fal_log_store (
	input wire logic clock_in, // System clock
	input wire logic init_in, // Clears the retained log
	input wire logic wr_in, // Store one entry
	input wire fal_pkg::fal_entry_t wr_entry_in, // Entry to store
	input wire logic [3:0] rd_age_in, // 0 selects the newest entry
	output fal_pkg::fal_entry_t rd_entry_out, // Selected entry
	output logic [3:0] rd_num_out, // Sequential number of selected entry
	output logic rd_valid_out, // Selected entry exists
	output logic [3:0] count_out // Entries held
);
	import fal_pkg::*;

	fal_entry_t mem_r [LOG_DEPTH];
	logic [3:0] wr_ptr_r;
	logic [3:0] count_r;
	logic [4:0] rd_idx;

	// ==========================================================
	// Storage: retained across a warm reset; init resets only the pointer and count
	// ==========================================================
	always_ff @(posedge clock_in) begin
		if (wr_in) begin
			mem_r[wr_ptr_r] <= wr_entry_in;
		end
	end

	// Pointer wraps so the oldest slot is overwritten when full
	always_ff @(posedge clock_in) begin
		if (init_in) begin
			wr_ptr_r <= 4'h0;
			count_r <= 4'h0;
		end else if (wr_in) begin
			wr_ptr_r <= (wr_ptr_r == LOG_LAST) ? 4'h0 : wr_ptr_r + 4'h1;
			if (count_r != LOG_DEPTH) begin
				count_r <= count_r + 4'h1;
			end
		end
	end

	// ==========================================================
	// Read by age, newest first
	// ==========================================================
	always_comb begin
		rd_idx = {1'b0, wr_ptr_r} + LOG_DEPTH5 - 5'h01 - {1'b0, rd_age_in};
		if (rd_idx >= LOG_DEPTH5) begin
			rd_idx = rd_idx - LOG_DEPTH5;
		end
		rd_valid_out = (rd_age_in < count_r);
		rd_entry_out = rd_valid_out ? mem_r[rd_idx[3:0]] : '0;
		rd_num_out = rd_valid_out ? (count_r - 4'h1 - rd_age_in) : 4'h0;
		count_out = count_r;
	end

endmodule // fal_log_store
`default_nettype wire

/* hw/fal_pkg.sv */
package fal_pkg;

	// ==========
	// Clock and timing
	// ==========
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_PERIOD_NS = 10_000_000; // 10 ms timestamp tick
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int FLASH_HALF_NS = 500_000_000; // Half period of display flashing
	localparam int FLASH_CYCLES_DEF = FLASH_HALF_NS / CLK_PERIOD_NS;
	localparam logic [12:0] TICKS_PER_MIN_LAST = 13'h176f; // 6000 ticks per minute, minus one
	localparam logic [5:0] MIN_LAST = 6'h3b;
	localparam logic [4:0] HOUR_LAST = 5'h17;
	localparam logic [30:0] TICK_TOTAL_LAST = 31'h7fffffff; // Wrap near 248.55 days
	localparam logic [5:0] BCD_TEN = 6'h0a;

	// ==========
	// Alarm thresholds
	// ==========
	localparam logic [3:0] AIN_MODE_LO = 4'h8;
	localparam logic [3:0] AIN_MODE_HI = 4'hb;
	localparam logic [15:0] LOOP_LOSS_UA = 16'h07d0; // 2 mA in microamps
	localparam logic [9:0] LINE_SPLIT_V = 10'h19f; // 415
	localparam logic [10:0] BUS_TRIP_HI_V = 11'h2e5; // 741 VDC
	localparam logic [10:0] BUS_TRIP_LO_V = 11'h29d; // 669 VDC

	// ==========
	// Display codes (values are arbitrary internal ids)
	// ==========
	localparam logic [7:0] ALM_NONE = 8'h00;
	localparam logic [7:0] ALM_ANALOG_LOSS = 8'h01;
	localparam logic [7:0] ALM_HIGH_BUS = 8'h02;
	localparam logic [7:0] ALM_IDENT_EN = 8'h03;
	localparam logic [7:0] ALM_IDENT_AC = 8'h04; // ident_active_code
	localparam logic [7:0] ALM_TUNE_EN = 8'h05;
	localparam logic [7:0] ALM_TUNE_AC = 8'h06; // tune_active_code

	// ==========
	// Error log
	// ==========
	localparam logic [3:0] LOG_DEPTH = 4'ha;
	localparam logic [3:0] LOG_LAST = 4'h9;
	localparam logic [4:0] LOG_DEPTH5 = 5'h0a;

	// ==========
	// Register map (byte addresses)
	// ==========
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_LOG_SEL = 8'h0c;
	localparam logic [7:0] REG_LOG_DATA = 8'h10;
	localparam logic [7:0] REG_CLOCK = 8'h14;
	localparam logic [7:0] REG_LOG_CNT = 8'h18;
	localparam logic [7:0] REG_LOG_TIME = 8'h1c;
	localparam int CTRL_IDENT_BIT = 0;
	localparam int CTRL_TUNE_BIT = 1;
	localparam int CTRL_ETM_BIT = 2;
	localparam int CTRL_SRC_LSB = 4;
	localparam int CTRL_SRC_W = 2;
	localparam int CFG_LINE_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic [31:0] CFG_RESET = 32'h00000000;
	localparam logic [31:0] CTRL_MASK = 32'h00000033;
	localparam logic [31:0] CFG_MASK = 32'h0003ff0f;
	localparam logic [31:0] LOG_SEL_MASK = 32'h0000000f;

	// ==========
	// Carriers
	// ==========
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} fal_avs_req_t;

	typedef struct packed {
		logic [10:0] bus_volt;
		logic [15:0] loop_ua;
	} fal_meas_t;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
	} fal_entry_t;

	typedef enum logic [1:0] {
		PR_OFF = 2'b00,
		PR_ARMED = 2'b01,
		PR_ACTIVE = 2'b10
	} fal_proc_t;

endpackage

/* hw/fal_top.sv */
// Contract
// - Active alarm flashes its code; drive keeps running.
// - Alarm code disappears by itself once its condition is gone.
// - Any fault stops the drive output and turns the run indicator off.
// - First fault is latched and shown; later faults do not replace it.
// - Latched fault clears only by stop key or selected source fault reset.
// - Every fault, latched or not, is written into the error log.
// - Nothing outside the log registers shows that the log holds entries.
// - The log keeps the ten most recent faults.
// - Reading the log gives the newest entry first, then older ones.
// - Entries are numbered sequentially; newest has the highest number, at most 9.
// - When full, a new fault pushes out the oldest entry.
// - Each entry carries a relative day from a counter wrapping at 248.55 days.
// - Each entry carries a 24-hour time, hour digits then two minute digits.
// - Elapsed-time reset clears the day and time counter.
// - Log and day/time values survive loss of power.
// - Analog mode 8 to 11 with loop below 2 mA raises signal loss alarm.
// - High bus alarm above 741 V if line above 415, else above 669 V.
// - Ident enabled shows enabled alarm; on start shows ident active alarm.
// - Stop key aborts identification in progress.
// - Ident enable off cancels pending identification and its alarm.
// - Tune enabled shows enabled alarm; on start shows tune active alarm.
// - Tune enable off cancels pending self-tuning and its alarm.
// - Operator must read the log to see every fault.
`timescale 1ns/1ns
`default_nettype none
module fal_top #(
	parameter int TICK_CYCLES = fal_pkg::TICK_CYCLES_DEF, // Cycles per 10 ms tick
	parameter int FLASH_CYCLES = fal_pkg::FLASH_CYCLES_DEF // Cycles per flash half period
) (
	input wire logic clock_in, // 125 MHz system clock
	input wire logic resetn_in, // Synchronous reset, active low
	input wire logic storage_init_in, // Clears retained log and clock
	input wire fal_pkg::fal_avs_req_t avs_req_in, // Avalon-MM request
	output logic [31:0] avs_readdata_out, // Avalon-MM read data
	output logic avs_waitrequest_out, // Avalon-MM wait request
	input wire logic fault_valid_in, // Fault detected this cycle
	input wire logic [7:0] fault_code_in, // Code of detected fault
	input wire fal_pkg::fal_meas_t meas_in, // Bus voltage and loop current
	input wire logic run_cmd_in, // Drive start/run request
	input wire logic stop_key_in, // Stop/reset key pulse
	input wire logic [3:0] fault_reset_src_in, // Fault reset per control source
	input wire logic ident_done_in, // Identification finished
	input wire logic tune_done_in, // Self-tuning finished
	output logic drive_enable_out, // Power stage enable, low to coast
	output logic run_indicator_out, // run_indicator
	output logic [7:0] display_code_out, // Code shown, zero when blank
	output logic display_lit_out, // Flash phase, high while lit
	output logic display_fault_out, // Shown code is a fault
	output logic ident_run_out, // Identification in progress
	output logic tune_run_out // Self-tuning in progress
);
	import fal_pkg::*;

	localparam logic [20:0] TICK_LAST = 21'(TICK_CYCLES - 1);
	localparam logic [25:0] FLASH_LAST = 26'(FLASH_CYCLES - 1);

	// ==========================================================
	// Functions
	// ==========================================================
	// Procedure sequencing shared by identification and self-tuning
	function automatic fal_proc_t proc_next(input fal_proc_t st, input logic en, input logic run,
		input logic stop, input logic done);
		case (st)
			PR_OFF: begin
				proc_next = en ? PR_ARMED : PR_OFF;
			end
			PR_ARMED: begin
				proc_next = !en ? PR_OFF : (run ? PR_ACTIVE : PR_ARMED);
			end
			PR_ACTIVE: begin
				proc_next = (!en || stop || done) ? PR_OFF : PR_ACTIVE;
			end
			default: begin
				proc_next = PR_OFF;
			end
		endcase
	endfunction

	// Byte-lane merge of a write into a register
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		be_merge = ((old & ~m) | (wd & m)) & mask;
	endfunction

	// Two BCD digits of a value below 60
	function automatic logic [7:0] bcd2(input logic [5:0] v);
		logic [5:0] t;
		t = v / BCD_TEN;
		bcd2 = {t[3:0], 4'(v - t * BCD_TEN)};
	endfunction

	// ==========================================================
	// Declarations
	// ==========================================================
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [31:0] ctrl_r;
	logic [31:0] cfg_r;
	logic [3:0] log_age_r;
	logic wr_fire;
	logic etm_reset;
	logic [20:0] tick_cnt_r;
	logic [12:0] tick_min_r;
	logic [5:0] min_r;
	logic [4:0] hour_r;
	logic [7:0] day_r;
	logic [30:0] total_r;
	logic tick;
	logic fault_latched_r;
	logic [7:0] fault_code_r;
	logic clear_req;
	fal_proc_t ident_st_r;
	fal_proc_t tune_st_r;
	fal_proc_t ident_nxt;
	fal_proc_t tune_nxt;
	logic [7:0] alarm_code;
	logic [25:0] flash_cnt_r;
	logic lit_r;
	logic drive_en_r;
	logic run_ind_r;
	logic [7:0] disp_code_r;
	logic disp_fault_r;
	fal_entry_t new_entry;
	fal_entry_t rd_entry;
	logic [3:0] rd_num;
	logic rd_valid;
	logic [3:0] log_count;

	// ==========================================================
	// Avalon-MM slave: one wait cycle, then the answer
	// ==========================================================
	// Wait is high at idle so a request is never taken before decode
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			wait_r <= 1'b1;
		end else if (!wait_r) begin
			wait_r <= 1'b1;
		end else if (avs_req_in.read || avs_req_in.write) begin
			wait_r <= 1'b0;
		end
	end

	assign wr_fire = avs_req_in.write && !wait_r;
	assign etm_reset = wr_fire && (avs_req_in.address == REG_CTRL) && avs_req_in.byteenable[0]
		&& avs_req_in.writedata[CTRL_ETM_BIT];

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = 32'h00000000;
		case (avs_req_in.address)
			REG_CTRL: begin
				rdata_nxt = ctrl_r;
			end
			REG_CFG: begin
				rdata_nxt = cfg_r;
			end
			REG_STATUS: begin
				// Log occupancy is deliberately absent here
				rdata_nxt = {8'h00, alarm_code, 1'b0, tune_st_r, ident_st_r, run_ind_r, drive_en_r,
					fault_latched_r, disp_code_r};
			end
			REG_LOG_SEL: begin
				rdata_nxt = {28'h0000000, log_age_r};
			end
			REG_LOG_DATA: begin
				rdata_nxt = {8'h00, rd_entry.day, 3'h0, rd_valid, rd_num, rd_entry.code};
			end
			REG_LOG_TIME: begin
				rdata_nxt = {16'h0000, bcd2({1'b0, rd_entry.hour}), bcd2(rd_entry.minute)};
			end
			REG_CLOCK: begin
				rdata_nxt = {8'h00, day_r, bcd2({1'b0, hour_r}), bcd2(min_r)};
			end
			REG_LOG_CNT: begin
				rdata_nxt = {28'h0000000, log_count};
			end
			default: begin
				rdata_nxt = 32'h00000000;
			end
		endcase
	end

	// Read data is captured as wait drops and stands for the answer cycle
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			rdata_r <= 32'h00000000;
		end else if (wait_r && avs_req_in.read) begin
			rdata_r <= rdata_nxt;
		end
	end

	// Control register; finished or aborted procedures clear their enable
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			ctrl_r <= CTRL_RESET;
		end else if (wr_fire && avs_req_in.address == REG_CTRL) begin
			ctrl_r <= be_merge(ctrl_r, avs_req_in.writedata, avs_req_in.byteenable, CTRL_MASK)
				& ~(32'h00000001 << CTRL_ETM_BIT);
		end else begin
			if (ident_st_r == PR_ACTIVE && ident_nxt == PR_OFF) begin
				ctrl_r[CTRL_IDENT_BIT] <= 1'b0;
			end
			if (tune_st_r == PR_ACTIVE && tune_nxt == PR_OFF) begin
				ctrl_r[CTRL_TUNE_BIT] <= 1'b0;
			end
		end
	end

	// Configuration and log selection
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			cfg_r <= CFG_RESET;
			log_age_r <= 4'h0;
		end else if (wr_fire) begin
			if (avs_req_in.address == REG_CFG) begin
				cfg_r <= be_merge(cfg_r, avs_req_in.writedata, avs_req_in.byteenable, CFG_MASK);
			end
			if (avs_req_in.address == REG_LOG_SEL) begin
				log_age_r <= 4'(be_merge({28'h0000000, log_age_r}, avs_req_in.writedata,
					avs_req_in.byteenable, LOG_SEL_MASK));
			end
		end
	end

	// ==========================================================
	// Day and time counter, retained like the log
	// ==========================================================
	assign tick = (tick_cnt_r == TICK_LAST);

	always_ff @(posedge clock_in) begin
		if (!resetn_in || tick) begin
			tick_cnt_r <= 21'h000000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 21'h000001;
		end
	end

	// Resetn does not touch these: they stand for the retained values
	always_ff @(posedge clock_in) begin
		if (storage_init_in || etm_reset) begin
			tick_min_r <= 13'h0000;
			min_r <= 6'h00;
			hour_r <= 5'h00;
			day_r <= 8'h00;
			total_r <= 31'h00000000;
		end else if (tick) begin
			if (total_r == TICK_TOTAL_LAST) begin
				// Relative counter rolls over as a whole
				tick_min_r <= 13'h0000;
				min_r <= 6'h00;
				hour_r <= 5'h00;
				day_r <= 8'h00;
				total_r <= 31'h00000000;
			end else begin
				total_r <= total_r + 31'h00000001;
				if (tick_min_r != TICKS_PER_MIN_LAST) begin
					tick_min_r <= tick_min_r + 13'h0001;
				end else begin
					tick_min_r <= 13'h0000;
					if (min_r != MIN_LAST) begin
						min_r <= min_r + 6'h01;
					end else begin
						min_r <= 6'h00;
						if (hour_r != HOUR_LAST) begin
							hour_r <= hour_r + 5'h01;
						end else begin
							hour_r <= 5'h00;
							day_r <= day_r + 8'h01;
						end
					end
				end
			end
		end
	end

	// ==========================================================
	// Fault latch
	// ==========================================================
	assign clear_req = stop_key_in || fault_reset_src_in[ctrl_r[CTRL_SRC_LSB +: CTRL_SRC_W]];

	// A new fault in the clearing cycle is latched, not lost
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			fault_latched_r <= 1'b0;
			fault_code_r <= ALM_NONE;
		end else if (fault_valid_in && (!fault_latched_r || clear_req)) begin
			fault_latched_r <= 1'b1;
			fault_code_r <= fault_code_in;
		end else if (clear_req) begin
			fault_latched_r <= 1'b0;
		end
	end

	// Every fault is logged with its timestamp
	assign new_entry = '{code: fault_code_in, day: day_r, hour: hour_r, minute: min_r};

	fal_log_store u_log (
		.clock_in(clock_in),
		.init_in(storage_init_in),
		.wr_in(fault_valid_in),
		.wr_entry_in(new_entry),
		.rd_age_in(log_age_r),
		.rd_entry_out(rd_entry),
		.rd_num_out(rd_num),
		.rd_valid_out(rd_valid),
		.count_out(log_count)
	);

	// ==========================================================
	// Identification and self-tuning sequencing
	// ==========================================================
	assign ident_nxt = proc_next(ident_st_r, ctrl_r[CTRL_IDENT_BIT], run_cmd_in, stop_key_in,
		ident_done_in);
	assign tune_nxt = proc_next(tune_st_r, ctrl_r[CTRL_TUNE_BIT], run_cmd_in, stop_key_in,
		tune_done_in);

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			ident_st_r <= PR_OFF;
			tune_st_r <= PR_OFF;
		end else begin
			ident_st_r <= ident_nxt;
			tune_st_r <= tune_nxt;
		end
	end

	// ==========================================================
	// Alarm evaluation, purely from present conditions
	// ==========================================================
	always_comb begin
		alarm_code = ALM_NONE;
		if (cfg_r[3:0] >= AIN_MODE_LO && cfg_r[3:0] <= AIN_MODE_HI && meas_in.loop_ua < LOOP_LOSS_UA) begin
			alarm_code = ALM_ANALOG_LOSS;
		end
		if ((cfg_r[CFG_LINE_LSB +: 10] > LINE_SPLIT_V) ? (meas_in.bus_volt > BUS_TRIP_HI_V)
			: (meas_in.bus_volt > BUS_TRIP_LO_V)) begin
			alarm_code = ALM_HIGH_BUS;
		end
		if (tune_st_r == PR_ARMED) begin
			alarm_code = ALM_TUNE_EN;
		end
		if (ident_st_r == PR_ARMED) begin
			alarm_code = ALM_IDENT_EN;
		end
		if (tune_st_r == PR_ACTIVE) begin
			alarm_code = ALM_TUNE_AC;
		end
		if (ident_st_r == PR_ACTIVE) begin
			alarm_code = ALM_IDENT_AC;
		end
	end

	// ==========================================================
	// Display and drive outputs
	// ==========================================================
	// Free-running flash phase shared by alarms and faults
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			flash_cnt_r <= 26'h0000000;
			lit_r <= 1'b1;
		end else if (flash_cnt_r == FLASH_LAST) begin
			flash_cnt_r <= 26'h0000000;
			lit_r <= !lit_r;
		end else begin
			flash_cnt_r <= flash_cnt_r + 26'h0000001;
		end
	end

	// Fault outranks alarm; alarms never touch the drive enable
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			disp_code_r <= ALM_NONE;
			disp_fault_r <= 1'b0;
		end else begin
			disp_code_r <= fault_latched_r ? fault_code_r : alarm_code;
			disp_fault_r <= fault_latched_r;
		end
	end

	// Coast at once on a fault, on the same edge that the latch sets
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			drive_en_r <= 1'b0;
			run_ind_r <= 1'b0;
		end else begin
			drive_en_r <= run_cmd_in && !fault_latched_r && !fault_valid_in;
			run_ind_r <= run_cmd_in && !fault_latched_r && !fault_valid_in;
		end
	end

	assign avs_waitrequest_out = wait_r;
	assign avs_readdata_out = rdata_r;
	assign drive_enable_out = drive_en_r;
	assign run_indicator_out = run_ind_r;
	assign display_code_out = disp_code_r;
	assign display_lit_out = lit_r && (disp_code_r != ALM_NONE);
	assign display_fault_out = disp_fault_r;
	assign ident_run_out = (ident_st_r == PR_ACTIVE);
	assign tune_run_out = (tune_st_r == PR_ACTIVE);

endmodule // fal_top
`default_nettype wire

/* test/fal_keypad.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Keypad and control source model
// ==========================================
module fal_keypad (
	input wire logic clock_in, // System clock
	input wire logic press_in, // One press request
	input wire logic via_src_in, // Press comes from a source
	input wire logic [1:0] src_in, // Source that presses
	output logic stop_key_out, // Stop/reset key
	output logic [3:0] fault_reset_src_out // Reset per source
);
	// Quiet until the first edge so the block never sees a floating key
	initial begin
		stop_key_out = 1'b0;
		fault_reset_src_out = 4'h0;
	end
	// One clean pulse per press; a held key would clear twice
	always @(posedge clock_in) begin
		stop_key_out <= press_in && !via_src_in;
		fault_reset_src_out <= (press_in && via_src_in) ? 4'h1 << src_in : 4'h0;
	end
endmodule // fal_keypad
`default_nettype wire

/* test/fal_top_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Fault and alarm port checks
// ==========================================
module fal_top_chk
	import fal_pkg::*;
#(
	parameter int TICK_CYCLES = 4, // Tick length
	parameter int FLASH_CYCLES = 8 // Flash half period
) (
	input wire logic clock_in, // Clock
	input wire logic resetn_in, // Reset, active low
	input wire logic fault_valid_in, // Fault pulse
	input wire logic [7:0] fault_code_in, // Fault code
	input wire fal_pkg::fal_meas_t meas_in, // Measurements
	input wire logic run_cmd_in, // Run request
	input wire logic stop_key_in, // Stop key
	input wire logic [3:0] fault_reset_src_in, // Source resets
	input wire logic drive_enable_out, // Drive enable
	input wire logic run_indicator_out, // Run lamp
	input wire logic [7:0] display_code_out, // Shown code
	input wire logic display_fault_out, // Shown code is fault
	input wire logic ident_run_out // Identification running
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!resetn_in);
	// The display lags the latch by one edge, hence the depth-two looks back
	fault_coast_a: assert property (fault_valid_in |=> !drive_enable_out)
		else $error("drive still enabled after fault");
	lamp_follow_a: assert property (run_indicator_out == drive_enable_out)
		else $error("run lamp differs from drive enable");
	first_shown_a: assert property (
		fault_valid_in && !display_fault_out && !$past(fault_valid_in)
		|=> ##1 display_fault_out && display_code_out == $past(fault_code_in, 2))
		else $error("first fault not shown");
	first_kept_a: assert property (
		display_fault_out && !$past(stop_key_in) && $past(fault_reset_src_in) == 4'h0
		|=> display_fault_out && $stable(display_code_out))
		else $error("latched fault replaced");
	clear_cause_a: assert property (
		$fell(display_fault_out) |-> $past(stop_key_in, 2) || $past(fault_reset_src_in, 2) != 4'h0
		|| !$past(resetn_in) || !$past(resetn_in, 2))
		else $error("fault cleared without reset request");
	run_keep_a: assert property (
		run_cmd_in && !fault_valid_in && !display_fault_out && !$past(fault_valid_in) |=> drive_enable_out)
		else $error("drive stopped without fault");
	alarm_gone_a: assert property (
		$past(meas_in.bus_volt) <= BUS_TRIP_LO_V && $past(meas_in.loop_ua) >= LOOP_LOSS_UA && !display_fault_out
		|-> display_code_out != ALM_HIGH_BUS && display_code_out != ALM_ANALOG_LOSS)
		else $error("alarm shown without cause");
	stop_abort_a: assert property (ident_run_out && stop_key_in |=> !ident_run_out)
		else $error("stop key did not abort identification");
endmodule // fal_top_chk
bind fal_top fal_top_chk #(.TICK_CYCLES(TICK_CYCLES), .FLASH_CYCLES(FLASH_CYCLES)) fal_top_chk_inst (
	.clock_in, .resetn_in, .fault_valid_in, .fault_code_in, .meas_in, .run_cmd_in, .stop_key_in,
	.fault_reset_src_in, .drive_enable_out, .run_indicator_out, .display_code_out, .display_fault_out,
	.ident_run_out);
`default_nettype wire

/* test/tb_fal_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_fal_top;
	import fal_pkg::*;
	localparam int TICKS = 4;
	logic clock_in = 1'b0, resetn_in = 1'b0, storage_init_in = 1'b1, fault_valid_in = 1'b0, run_cmd_in = 1'b0;
	logic ident_done_in = 1'b0, tune_done_in = 1'b0, press = 1'b0, via_src = 1'b0, stop_key_in;
	logic drive_enable_out, run_indicator_out, display_lit_out, display_fault_out, ident_run_out, tune_run_out;
	logic avs_waitrequest_out;
	logic [1:0] src = 2'h0;
	logic [3:0] fault_reset_src_in;
	logic [7:0] fault_code_in = 8'h00, display_code_out;
	logic [31:0] avs_readdata_out, rv;
	fal_avs_req_t avs_req_in = '0;
	fal_meas_t meas_in = '0;
	logic [31:0] eq[$], mq[$];
	int n_fail = 0, n_tests = 0, cyc = 0;
	fal_top #(.TICK_CYCLES(TICKS), .FLASH_CYCLES(8)) fal_top_inst (.*);
	fal_keypad fal_keypad_inst (.clock_in, .press_in(press), .via_src_in(via_src), .src_in(src),
		.stop_key_out(stop_key_in), .fault_reset_src_out(fault_reset_src_in));
	// ======
	// Clock, timeout and result watcher
	// ======
	initial begin
		forever #4 clock_in = ~clock_in;
	end
	// The one-minute wait dominates, about 24k cycles
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail = n_fail + 1;
			test_done();
		end
	end
	// Oldest note belongs to the read that completes at this edge
	always @(posedge clock_in) begin
		if (avs_req_in.read && avs_waitrequest_out === 1'b0 && eq.size() > 0)
			chk(avs_readdata_out & mq.pop_front(), eq.pop_front());
	end
	// ======
	// Tasks
	// ======
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	// Request held until waitrequest is seen low, then released
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		avs_req_in <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
		do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
		avs_req_in <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		eq.push_back(e & m);
		mq.push_back(m);
		acc(1'b0, a, 32'h0);
	endtask
	task automatic st(input logic [7:0] c, input logic [15:0] s);
		tk(3);
		rd(REG_STATUS, {8'h0, c, s}, 32'h00ff7800);
	endtask
	task automatic alm(input logic [10:0] v, input logic [15:0] l, input logic [7:0] c);
		meas_in <= '{bus_volt: v, loop_ua: l};
		st(c, 16'h0);
	endtask
	task automatic flt(input logic [7:0] c);
		@(posedge clock_in);
		fault_valid_in <= 1'b1;
		fault_code_in <= c;
		@(posedge clock_in);
		fault_valid_in <= 1'b0;
		tk(3);
	endtask
	task automatic key(input logic s, input logic [1:0] n);
		@(posedge clock_in);
		press <= 1'b1;
		via_src <= s;
		src <= n;
		@(posedge clock_in);
		press <= 1'b0;
		tk(3);
	endtask
	// ======
	// Main sequence
	// ======
	initial begin
		rv = $urandom(32'hbf6fc46d);
		tk(20);
		storage_init_in <= 1'b0;
		resetn_in <= 1'b1;
		rd(REG_CTRL, CTRL_RESET, 32'hffffffff);
		rd(8'h20, 32'h0, 32'hffffffff);
		// Random mode 8..11 and line at or below the split
		rv = {14'h0, 10'($urandom % 416), 4'h0, 4'(8 + $urandom % 4)};
		acc(1'b1, REG_CFG, rv);
		rd(REG_CFG, rv, 32'hffffffff);
		alm(11'h258, 16'h07cf, ALM_ANALOG_LOSS);
		alm(11'h258, LOOP_LOSS_UA, ALM_NONE);
		alm(11'h29e, LOOP_LOSS_UA, ALM_HIGH_BUS);
		alm(BUS_TRIP_LO_V, LOOP_LOSS_UA, ALM_NONE);
		acc(1'b1, REG_CFG, 32'h0001a007);
		alm(11'h258, 16'h07cf, ALM_NONE);
		alm(BUS_TRIP_HI_V, LOOP_LOSS_UA, ALM_NONE);
		alm(11'h2e6, LOOP_LOSS_UA, ALM_HIGH_BUS);
		// Alarm stays up while the drive runs, then faults override it
		run_cmd_in <= 1'b1;
		tk(3);
		rd(REG_STATUS, {8'h0, ALM_HIGH_BUS, 8'h06, ALM_HIGH_BUS}, 32'h00ff07ff);
		flt(8'h31);
		rd(REG_STATUS, 32'h00000131, 32'h000007ff);
		flt(8'h32);
		rd(REG_STATUS, 32'h00000131, 32'h000007ff);
		rd(REG_LOG_CNT, 32'h2, 32'hf);
		rd(REG_LOG_DATA, 32'h00001132, 32'h1fff);
		acc(1'b1, REG_CTRL, 32'h20);
		key(1'b1, 2'h1);
		rd(REG_STATUS, 32'h100, 32'h100);
		key(1'b1, 2'h2);
		rd(REG_STATUS, 32'h0, 32'h100);
		flt(8'h33);
		key(1'b0, 2'h0);
		rd(REG_STATUS, 32'h0, 32'h100);
		// Overfill the log by two
		for (int i = 0; i < 9; i++)
			flt(8'h40 + 8'(i));
		rd(REG_LOG_CNT, 32'ha, 32'hf);
		rd(REG_LOG_DATA, 32'h00001948, 32'h1fff);
		acc(1'b1, REG_LOG_SEL, 32'h9);
		rd(REG_LOG_DATA, 32'h00001033, 32'h1fff);
		acc(1'b1, REG_LOG_SEL, 32'ha);
		rd(REG_LOG_DATA, 32'h0, 32'hffffffff);
		key(1'b0, 2'h0);
		meas_in <= '0;
		run_cmd_in <= 1'b0;
		rd(REG_STATUS, 32'h0, 32'h1ff);
		// Identification and self-tuning
		acc(1'b1, REG_CTRL, 32'h1);
		st(ALM_IDENT_EN, 16'h0800);
		run_cmd_in <= 1'b1;
		st(ALM_IDENT_AC, 16'h1000);
		key(1'b0, 2'h0);
		st(ALM_NONE, 16'h0);
		run_cmd_in <= 1'b0;
		acc(1'b1, REG_CTRL, 32'h1);
		acc(1'b1, REG_CTRL, 32'h0);
		st(ALM_NONE, 16'h0);
		acc(1'b1, REG_CTRL, 32'h2);
		st(ALM_TUNE_EN, 16'h2000);
		run_cmd_in <= 1'b1;
		st(ALM_TUNE_AC, 16'h4000);
		acc(1'b1, REG_CTRL, 32'h0);
		st(ALM_NONE, 16'h0);
		// Elapsed-time reset, one minute, then a stamped fault
		acc(1'b1, REG_CTRL, 32'h4);
		tk(6000 * TICKS + 20);
		rd(REG_CLOCK, 32'h0001, 32'h00ffffff);
		flt(8'h50);
		acc(1'b1, REG_LOG_SEL, 32'h0);
		rd(REG_LOG_TIME, 32'h0001, 32'hffff);
		rd(REG_LOG_DATA, 32'h00001950, 32'h00ff1fff);
		acc(1'b1, REG_CTRL, 32'h4);
		rd(REG_CLOCK, 32'h0, 32'h00ffffff);
		// Log survives a reset
		resetn_in <= 1'b0;
		tk(2);
		resetn_in <= 1'b1;
		rd(REG_LOG_CNT, 32'ha, 32'hf);
		test_done();
	end
endmodule // tb_fal_top
`default_nettype wire
